/* File: verilog/touch_i2c_pkg.sv */
// Purpose: Shared constants for the touch controller serial port, both ends
// Assumes: 125 MHz system clock on both ends
// Notes: Address layout and bus timing counts
package touch_i2c_pkg;
  // ----------------------------------------
  // Slave address
  // ----------------------------------------
  localparam logic [4:0] ADDR_FIXED = 5'h0f;
  localparam logic [1:0] STRAP_FLOAT = 2'h0;
  localparam logic [1:0] STRAP_GND = 2'h1;
  localparam logic [1:0] STRAP_VDD = 2'h2;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;
  // ----------------------------------------
  // Strap pin encoding (floating, ground, supply)
  // ----------------------------------------
  localparam logic [1:0] PIN_FLOAT = 2'h0;
  localparam logic [1:0] PIN_LOW = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCL_HALF_NS = 1300;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] REG_RESET = 8'h00;
endpackage

/* File: verilog/touch_i2c_if.sv */
// Purpose: Two-wire bus joining master and touch slave
// Assumes: Open-drain lines with pull-up
// Notes: Wire level resolved here from the enables
`timescale 1ns/1ps
interface touch_i2c_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // ----------------------------------------
  // Wired-AND with pull-up
  // ----------------------------------------
  assign scl = !(scl_oe && !scl_o);
  assign sda = !(sda_m_oe && !sda_m_o) && !(sda_s_oe && !sda_s_o);
  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface

/* File: verilog/touch_i2c_slave.sv */
// Purpose: Serial slave port of the touch controller
// Assumes: Bus lines asynchronous to clk; register file outside
// Notes: Register index advances after each byte sent to the master
`timescale 1ns/1ps
module touch_i2c_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Bus
  touch_i2c_if.slave bus,
  // Strap
  input wire logic [1:0] strap_pin,
  input wire logic touch_channel_fifteen,
  // Register file side
  output logic [7:0] reg_index,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  output logic rd_strobe,
  input wire logic [7:0] rd_data
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_ADDR = 6'h02, ST_ACK = 6'h04,
    ST_RX = 6'h08, ST_TX = 6'h10, ST_RACK = 6'h20
  } state_t;
  state_t state_reg;
  logic [1:0] scl_sync, sda_sync;
  logic scl_reg, sda_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_reg;
  logic idx_phase_reg, dir_reg, tx_reg;
  logic [1:0] strapped_addr_bits;
  logic [7:0] reg_index_reg, wr_data_reg;
  logic wr_reg, rd_reg;
  logic [1:0] strap_meta_reg, strap_reg;
  logic chan_meta_reg, chan_reg;
  // ----------------------------------------
  // Input sync and edge decode
  // ----------------------------------------
  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = scl_s && !scl_reg;
  wire scl_fall = !scl_s && scl_reg;
  wire start_det = scl_s && scl_reg && sda_reg && !sda_s;
  wire stop_det = scl_s && scl_reg && !sda_reg && sda_s;
  // Strap decode, channel use forces 00
  assign strapped_addr_bits = chan_reg ? touch_i2c_pkg::STRAP_FLOAT :
    (strap_reg == touch_i2c_pkg::PIN_LOW) ? touch_i2c_pkg::STRAP_GND :
    (strap_reg == touch_i2c_pkg::PIN_HIGH) ? touch_i2c_pkg::STRAP_VDD : touch_i2c_pkg::STRAP_FLOAT;
  // Compare uses the synchronised straps at the deciding fall; a strap move mid-byte counts for that same byte
  wire [6:0] own_addr = {touch_i2c_pkg::ADDR_FIXED, strapped_addr_bits};
  wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Ack drives low; tx drives data bit, open drain
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = tx_reg;
  assign reg_index = reg_index_reg;
  assign wr_data = wr_data_reg;
  assign wr_strobe = wr_reg;
  assign rd_strobe = rd_reg;
  // Two-flop synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else if (clk_en) begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
      scl_reg <= scl_s;
      sda_reg <= sda_s;
    end
  end
  // ----------------------------------------
  // Strap synchronisers
  // ----------------------------------------
  // Strap levels come off pins, so two flops stand before the decode
  // Reset to the floating code, the answer of an unstrapped part
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_meta_reg <= touch_i2c_pkg::PIN_FLOAT;
      strap_reg <= touch_i2c_pkg::PIN_FLOAT;
      chan_meta_reg <= 1'b0;
      chan_reg <= 1'b0;
    end else if (clk_en) begin
      strap_meta_reg <= strap_pin;
      strap_reg <= strap_meta_reg;
      chan_meta_reg <= touch_channel_fifteen;
      chan_reg <= chan_meta_reg;
    end
  end
  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  // Drive changes only on SCL fall so data holds through the high phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      idx_phase_reg <= 1'b0;
      dir_reg <= 1'b0;
      tx_reg <= 1'b0;
      reg_index_reg <= touch_i2c_pkg::REG_RESET;
      wr_data_reg <= touch_i2c_pkg::REG_RESET;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else if (clk_en) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      // START and STOP win over any byte in flight
      if (start_det) begin
        state_reg <= ST_ADDR;
        bit_reg <= 4'h0;
        tx_reg <= 1'b0;
      end else if (stop_det) begin
        state_reg <= ST_IDLE;
        tx_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          ST_IDLE: tx_reg <= 1'b0;
          // Shift on each rise, decide on the fall after the eighth bit
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_reg <= rx_byte;
              bit_reg <= bit_reg + 4'h1;
            end
            if (scl_fall && bit_reg == 4'h8) begin
              bit_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == own_addr) begin
                  tx_reg <= 1'b1;
                  dir_reg <= shift_reg[0];
                  idx_phase_reg <= (shift_reg[0] == touch_i2c_pkg::DIR_WRITE);
                  state_reg <= ST_ACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                tx_reg <= 1'b1;
                state_reg <= ST_ACK;
                if (idx_phase_reg) begin
                  reg_index_reg <= shift_reg;
                  idx_phase_reg <= 1'b0;
                end else begin
                  wr_data_reg <= shift_reg;
                  wr_reg <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (dir_reg == touch_i2c_pkg::DIR_READ) begin
                shift_reg <= rd_data;
                rd_reg <= 1'b1;
                tx_reg <= !rd_data[7];
                state_reg <= ST_TX;
              end else begin
                // Write direction: release ack, take the next byte
                tx_reg <= 1'b0;
                state_reg <= ST_RX;
              end
            end
          end
          // New bit goes out on each fall, settled long before the rise
          ST_TX: begin
            if (scl_fall) begin
              if (bit_reg == 4'h7) begin
                tx_reg <= 1'b0;
                bit_reg <= 4'h0;
                reg_index_reg <= reg_index_reg + 8'h01;
                state_reg <= ST_RACK;
              end else begin
                tx_reg <= !shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_reg <= bit_reg + 4'h1;
              end
            end
          end
          // Ninth pulse of a read: high means the master wants no more
          ST_RACK: begin
            if (scl_rise && sda_s) begin
              state_reg <= ST_IDLE;
            end else if (scl_rise) begin
              state_reg <= ST_ACK;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

/* File: verilog/touch_i2c_master.sv */
// Purpose: Bus master end issuing register writes and reads
// Assumes: Single master, slave never stretches the clock
// Notes: One command at a time; busy while running
`timescale 1ns/1ps
module touch_i2c_master #(
  // Clock cycles per pacing tick; SCL is held high for one tick and low for two
  parameter int HALF_CYC = touch_i2c_pkg::SCL_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Bus
  touch_i2c_if.master bus,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_index,
  input wire logic [7:0] cmd_wdata,
  output logic done,
  output logic nack,
  output logic [7:0] rdata
);
  typedef enum logic [3:0] {
    M_IDLE = 4'h1, M_START = 4'h2, M_BIT = 4'h4, M_STOP = 4'h8
  } mstate_t;
  mstate_t st_reg;
  logic [15:0] cnt_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg;
  logic [2:0] byte_reg;
  logic [8:0] sh_reg;
  logic scl_reg, sda_reg, rd_reg, nack_reg, done_reg;
  logic [7:0] rdata_reg, idx_reg, wd_reg;
  logic [6:0] addr_reg;
  logic [1:0] sda_sync;
  // ----------------------------------------
  // Byte sequencing: addr W, index, then data or restart addr R, read
  // ----------------------------------------
  wire tick = cnt_reg == 16'(HALF_CYC - 1);
  wire sda_s = sda_sync[1];
  wire last_byte = byte_reg == 3'h2 && !rd_reg || byte_reg == 3'h3;
  wire [8:0] next_tx = (byte_reg == 3'h0) ? {idx_reg, 1'b1} :
    (!rd_reg) ? {wd_reg, 1'b1} : {addr_reg, touch_i2c_pkg::DIR_READ, 1'b1};
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = !scl_reg;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = !sda_reg;
  assign cmd_ready = st_reg == M_IDLE;
  assign done = done_reg;
  assign nack = nack_reg;
  assign rdata = rdata_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sda_sync <= 2'h3;
    end else if (clk_en) begin
      sda_sync <= {sda_sync[0], bus.sda};
    end
  end
  // Half-period pacing and bit engine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= M_IDLE;
      cnt_reg <= 16'h0000;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
      byte_reg <= 3'h0;
      sh_reg <= 9'h1ff;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      rd_reg <= 1'b0;
      nack_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= 8'h00;
      idx_reg <= 8'h00;
      wd_reg <= 8'h00;
      addr_reg <= 7'h00;
    end else if (clk_en) begin
      done_reg <= 1'b0;
      cnt_reg <= tick ? 16'h0000 : cnt_reg + 16'h0001;
      unique case (st_reg)
        M_IDLE: begin
          cnt_reg <= 16'h0000;
          if (cmd_valid) begin
            rd_reg <= cmd_read;
            addr_reg <= cmd_addr;
            idx_reg <= cmd_index;
            wd_reg <= cmd_wdata;
            sh_reg <= {cmd_addr, touch_i2c_pkg::DIR_WRITE, 1'b1};
            byte_reg <= 3'h0;
            nack_reg <= 1'b0;
            phase_reg <= 2'h0;
            st_reg <= M_START;
          end
        end
        M_START: if (tick) begin
          phase_reg <= phase_reg + 2'h1;
          unique case (phase_reg)
            2'h0: begin
              scl_reg <= 1'b1;
              sda_reg <= 1'b1;
            end
            2'h1: sda_reg <= 1'b0;
            default: begin
              scl_reg <= 1'b0;
              bit_reg <= 4'h0;
              phase_reg <= 2'h0;
              st_reg <= M_BIT;
            end
          endcase
        end
        M_BIT: if (tick) begin
          if (!scl_reg && phase_reg == 2'h0) begin
            sda_reg <= (byte_reg == 3'h3 && bit_reg == 4'h8) ? 1'b1 : sh_reg[8];
            phase_reg <= 2'h1;
          end else if (!scl_reg) begin
            scl_reg <= 1'b1;
          end else begin
            scl_reg <= 1'b0;
            phase_reg <= 2'h0;
            sh_reg <= {sh_reg[7:0], 1'b1};
            if (byte_reg == 3'h3 && bit_reg < 4'h8) begin
              rdata_reg <= {rdata_reg[6:0], sda_s};
            end
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h8) begin
              bit_reg <= 4'h0;
              if (byte_reg != 3'h3 && sda_s) begin
                nack_reg <= 1'b1;
                st_reg <= M_STOP;
              end else if (last_byte) begin
                st_reg <= M_STOP;
              end else if (byte_reg == 3'h1 && rd_reg) begin
                byte_reg <= 3'h2;
                sh_reg <= next_tx;
                phase_reg <= 2'h0;
                st_reg <= M_START;
              end else begin
                byte_reg <= byte_reg + 3'h1;
                sh_reg <= (byte_reg == 3'h2) ? 9'h1ff : next_tx;
              end
            end
          end
        end
        M_STOP: if (tick) begin
          phase_reg <= phase_reg + 2'h1;
          unique case (phase_reg)
            2'h0: sda_reg <= 1'b0;
            2'h1: scl_reg <= 1'b1;
            default: begin
              sda_reg <= 1'b1;
              done_reg <= 1'b1;
              phase_reg <= 2'h0;
              st_reg <= M_IDLE;
            end
          endcase
        end
        default: st_reg <= M_IDLE;
      endcase
    end
  end
endmodule

/* File: testbench/touch_i2c_port_chk.sv */
// Purpose: Wire-level checks of the two-wire port
// Assumes: Master and slave ends joined by one interface
// Notes: Bit counter restarts on every START
`timescale 1ns/1ps
module touch_i2c_port_chk #(
  parameter int HALF_CYC = touch_i2c_pkg::SCL_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus lines
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_reg;
  logic sda_reg;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic first_reg;
  logic first_next;
  logic dir_reg;
  logic dir_next;
  // One clock-high span, with room for the sync lag of the ends
  localparam int HIGH_MIN = HALF_CYC - 8;
  localparam int HIGH_MAX = HALF_CYC + 8;
  wire start_seen = scl && scl_reg && sda_reg && !sda;
  wire scl_rise = scl && !scl_reg;
  wire ninth_rise = scl_rise && cnt_reg == 4'h8;
  // Direction bit of the address byte, so read data bytes are known
  assign first_next = start_seen ? 1'b1 : ninth_rise ? 1'b0 : first_reg;
  assign dir_next = (scl_rise && cnt_reg == 4'h7 && first_reg) ? sda : dir_reg;
  wire read_data = dir_reg && !first_reg;
  // -------------------------------
  // Pulse count within a byte
  // -------------------------------
  assign cnt_next = start_seen ? 4'h0 : !scl_rise ? cnt_reg : (cnt_reg == 4'h8) ? 4'h0 : cnt_reg + 4'h1;
  always_ff @(posedge clk) begin
    scl_reg <= sys_rst ? 1'b1 : scl;
    sda_reg <= sys_rst ? 1'b1 : sda;
    cnt_reg <= sys_rst ? 4'h0 : cnt_next;
    first_reg <= sys_rst ? 1'b0 : first_next;
    dir_reg <= sys_rst ? 1'b0 : dir_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_ninth;
    $rose(scl) && cnt_reg == 4'h8;
  endsequence
  sequence s_slave_bit;
    $rose(scl) && sda_s_oe && !sda_s_o;
  endsequence
  sequence s_high_span;
    ##[HIGH_MIN:HIGH_MAX] $fell(scl);
  endsequence
  property p_idle; $fell(sys_rst) |-> (scl && sda && !scl_oe)[*8]; endproperty
  property p_stable; $changed(sda_s_oe) |-> !scl; endproperty
  property p_ack_hold; s_slave_bit |-> (sda_s_oe throughout s_high_span); endproperty
  property p_no_fight; s_slave_bit |-> !(sda_m_oe && !sda_m_o) && !sda; endproperty
  property p_start_free; scl && $fell(sda) |-> !sda_s_oe; endproperty
  property p_stop_idle; scl && $rose(sda) |-> ##1 (!sda_s_oe)[*8]; endproperty
  property p_ninth_master; s_ninth and (read_data) |-> !sda_s_oe; endproperty
  property p_data_slave; $rose(scl) && cnt_reg != 4'h8 && sda_m_oe && !sda_m_o |-> !sda_s_oe; endproperty
  a_idle: assert property (p_idle) else $error("bus not idle after reset");
  a_stable: assert property (p_stable) else $error("slave moved data while clock high");
  a_ack_hold: assert property (p_ack_hold) else $error("slave low not held over pulse");
  a_no_fight: assert property (p_no_fight) else $error("master not released under slave low");
  a_start_free: assert property (p_start_free) else $error("slave driving at START");
  a_stop_idle: assert property (p_stop_idle) else $error("slave driving after STOP");
  a_ninth_master: assert property (p_ninth_master) else $error("slave driving at master ack");
  a_data_slave: assert property (p_data_slave) else $error("slave driving over master bits");
endmodule

/* File: testbench/tb_touch_i2c_slave_port.sv */
// Purpose: Master end against slave end, write and read traffic
// Assumes: Register file modelled here on the slave side
// Notes: Shortened bit timing, about 30k cycles
`timescale 1ns/1ps
module tb_touch_i2c_slave_port;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_index = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [1:0] strap_pin = 2'h0;
  logic touch_channel_fifteen = 1'b0;
  logic cmd_ready, done, nack, wr_strobe, rd_strobe;
  logic [7:0] rdata, reg_index, wr_data, rd_data, idx, dat;
  logic [7:0] regs [256];
  logic [7:0] shadow [256];
  logic [9:0] exp_q [$];
  logic [9:0] mon_e;
  logic [1:0] pins [3] = '{touch_i2c_pkg::PIN_FLOAT, touch_i2c_pkg::PIN_LOW, touch_i2c_pkg::PIN_HIGH};
  logic [1:0] straps [3] = '{touch_i2c_pkg::STRAP_FLOAT, touch_i2c_pkg::STRAP_GND, touch_i2c_pkg::STRAP_VDD};
  int n_mismatch = 0;
  int cmp_count = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  // Short half period keeps the run small; the slave needs only a few cycles of margin
  localparam int HALF_CYC = 40;
  always #4 clk = ~clk;
  touch_i2c_if bus_if ();
  touch_i2c_master #(.HALF_CYC(HALF_CYC)) touch_i2c_master_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .done(done), .nack(nack), .rdata(rdata));
  touch_i2c_slave touch_i2c_slave_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .bus(bus_if),
    .strap_pin(strap_pin), .touch_channel_fifteen(touch_channel_fifteen), .reg_index(reg_index),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data));
  touch_i2c_port_chk #(.HALF_CYC(HALF_CYC)) touch_i2c_port_chk_inst (.clk(clk), .sys_rst(sys_rst),
    .scl_o(bus_if.scl_o), .scl_oe(bus_if.scl_oe), .sda_m_o(bus_if.sda_m_o), .sda_m_oe(bus_if.sda_m_oe),
    .sda_s_o(bus_if.sda_s_o),
    .sda_s_oe(bus_if.sda_s_oe), .scl(bus_if.scl), .sda(bus_if.sda));
  // Register file behind the slave
  assign rd_data = regs[reg_index];
  always @(posedge clk) begin
    if (wr_strobe === 1'b1) begin
      regs[reg_index] <= wr_data;
      wr_cnt <= wr_cnt + 1;
    end
    if (rd_strobe === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
    end
  end
  task check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Result watcher, oldest note first
  always @(negedge clk) begin
    if (done === 1'b1) begin
      mon_e = exp_q.pop_front();
      check("nack", {7'h00, mon_e[8]}, {7'h00, nack});
      if (mon_e[9]) check("rdata", mon_e[7:0], rdata);
    end
  end
  // One command; held until taken, then bounded wait for done
  task do_cmd(input logic rd, input logic [1:0] strap, input logic [7:0] ix, input logic [7:0] wd, input logic en);
    int t;
    t = 0;
    exp_q.push_back({rd, en, shadow[ix]});
    if (!rd && !en) shadow[ix] = wd;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_addr <= {touch_i2c_pkg::ADDR_FIXED, strap};
    cmd_index <= ix;
    cmd_wdata <= wd;
    do @(negedge clk); while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && t < 10000) begin
      @(negedge clk);
      t++;
    end
    if (t >= 10000) check("done", 8'h01, 8'h00);
    repeat (20) @(posedge clk);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog, well past the expected 30k cycles
  initial begin
    repeat (60000) @(posedge clk);
    check("watchdog", 8'h00, 8'h01);
    wrap_up;
  end
  initial begin
    void'($urandom(32'he601f8a2));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      idx = 8'($urandom);
      dat = 8'($urandom);
      strap_pin <= pins[k];
      do_cmd(touch_i2c_pkg::DIR_WRITE, straps[k], idx, dat, 1'b0);
      do_cmd(touch_i2c_pkg::DIR_READ, straps[k], idx, 8'h00, 1'b0);
      check("index after read", idx + 8'h01, reg_index);
      $display("test strap %0d done", k);
    end
    // Pin taken as touch channel: only strap 00 answers
    touch_channel_fifteen <= 1'b1;
    strap_pin <= touch_i2c_pkg::PIN_HIGH;
    idx = 8'($urandom);
    do_cmd(touch_i2c_pkg::DIR_WRITE, touch_i2c_pkg::STRAP_FLOAT, idx, 8'($urandom), 1'b0);
    do_cmd(touch_i2c_pkg::DIR_WRITE, touch_i2c_pkg::STRAP_VDD, idx + 8'h01, 8'h5a, 1'b1);
    check("write count", 8'h04, 8'(wr_cnt));
    check("read strobes", 8'h03, 8'(rd_cnt));
    check("written byte", shadow[idx], regs[idx]);
    $display("test touch channel done");
    wrap_up;
  end
endmodule
